// File: rtl/lcs_map.vh
// register offsets, reset values and timing constants for the led current and clock select block
// assumes byte-wide registers on the serial control interface's internal register port
`ifndef LCS_MAP_VH
`define LCS_MAP_VH
`define LCS_ADDR_CH7_CURRENT   8'h2C
`define LCS_ADDR_CH8_CURRENT   8'h2D
`define LCS_ADDR_CH9_CURRENT   8'h2E
`define LCS_ADDR_MISC          8'h05
`define LCS_ADDR_STATUS        8'h3A
`define LCS_CURRENT_RESET      8'hAF
`define LCS_CLKSEL_RESET       2'h0
`define LCS_BIT_INT_CLK_EN     0
`define LCS_BIT_DETECT_EN      1
`define LCS_BIT_EXT_IN_USE     0
`define LCS_SEL_FORCED_EXT     2'h0
`define LCS_SEL_FORCED_INT     2'h1
`define LCS_SEL_AUTO           2'h2
`define LCS_SEL_INTERNAL       2'h3
`define LCS_CURRENT_STEP_UA    100
`define LCS_DET_TIMEOUT_US     100
`define LCS_CLK_MHZ            125
// silence window of the detector in mclk cycles: 100 us at 125 MHz is 12500
`define LCS_DET_TIMEOUT_CYC    17'h030D4
`endif

// File: rtl/lcs_sync3.v
// three-stage synchroniser with agreement filter for an asynchronous pin
// assumes the pin is unrelated to mclk
`timescale 1ns/100ps
`default_nettype none
module lcs_sync3 (
   input  wire mclk,
   input  wire rst_n,
   input  wire pin_in,
   output reg  level_out
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   // s1 feeds only s2; a change counts once s2 and s3 agree
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg    <= 1'b0;
         s2_reg    <= 1'b0;
         s3_reg    <= 1'b0;
         level_out <= 1'b0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            level_out <= s3_reg;
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/lcs_led_current_clock_select.v
// channel 7..9 current setting registers and execution clock source selection
// assumes a byte register port from the serial control interface on mclk, and a slow
// internal oscillator and external clock pin both sampled as asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
`include "lcs_map.vh"

// Summary of operation
// - Each of channels 7, 8 and 9 holds an 8-bit unsigned current code worth 100 uA per step.
// - Each current register is read/write and resets to 8'hAF, which is 17.5 mA.
// - Program execution is clocked from the internal 32.7 kHz oscillator or the external clock pin.
// - In auto mode the external clock is used only when a detector sees it toggling; forced external mode uses it without detection.
// - The external clock is nominally 32.7 kHz and engine speed simply follows whatever rate is given.
// - The detector places no upper limit on the external clock frequency.
// - A read-only status bit at 3A reports external clock use, meaningful only with detect enable set.
// - The two-bit select field decodes 00 forced external, 01 forced internal, 10 auto, 11 internal, reset 00.
module lcs_led_current_clock_select (
   input  wire       mclk,
   input  wire       rst_n,
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   input  wire       int_osc_in,
   input  wire       ext_clk_pin,
   output reg  [7:0] ch7_current_code,
   output reg  [7:0] ch8_current_code,
   output reg  [7:0] ch9_current_code,
   output reg        exec_clk,
   output reg        exec_tick,
   output reg        external_clock_in_use_flag
);
   // last count of the silence window; presence ends when it is reached
   localparam [16:0] DET_LAST = `LCS_DET_TIMEOUT_CYC - 17'h00001;

   // execution clock source states, binary coded
   localparam [0:0] SRC_INT = 1'h0;
   localparam [0:0] SRC_EXT = 1'h1;

   // limitation: the detector only sees the pin through the synchroniser, so a
   // pin toggling faster than about a quarter of mclk is seen as a slower clock
   // or as a stuck level; presence is still never refused for being too fast,
   // and the engines follow the rate that actually reaches them

   reg  [1:0]  clk_sel_reg;
   reg  [16:0] det_cnt_reg;
   reg  [16:0] det_cnt_next;
   reg         ext_present_reg;
   reg         ext_present_next;
   reg         ext_prev_reg;
   reg         int_prev_reg;
   reg  [0:0]  src_state_reg;
   reg  [0:0]  src_state_next;
   reg         exec_clk_next;
   reg         exec_tick_next;
   reg         flag_next;
   reg         want_ext;
   wire        use_ext;
   wire        ext_lvl;
   wire        int_lvl;
   wire        ext_edge;
   wire        int_edge;
   wire        clock_detect_enable;

   assign clock_detect_enable = clk_sel_reg[`LCS_BIT_DETECT_EN];

   // both clock sources arrive from other domains, so each is filtered first
   lcs_sync3 u_sync_ext (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .pin_in    (ext_clk_pin),
      .level_out (ext_lvl)
   );

   lcs_sync3 u_sync_int (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .pin_in    (int_osc_in),
      .level_out (int_lvl)
   );

   assign ext_edge = ext_lvl & ~ext_prev_reg;
   assign int_edge = int_lvl & ~int_prev_reg;

   // register writes; current codes drive the current sources directly
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ch7_current_code <= `LCS_CURRENT_RESET;
         ch8_current_code <= `LCS_CURRENT_RESET;
         ch9_current_code <= `LCS_CURRENT_RESET;
         clk_sel_reg      <= `LCS_CLKSEL_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            `LCS_ADDR_CH7_CURRENT: ch7_current_code <= reg_wdata;
            `LCS_ADDR_CH8_CURRENT: ch8_current_code <= reg_wdata;
            `LCS_ADDR_CH9_CURRENT: ch9_current_code <= reg_wdata;
            `LCS_ADDR_MISC:        clk_sel_reg      <= reg_wdata[1:0];
            default: ;
         endcase
      end
   end

   // read mux; the status register ignores writes, unmapped reads give zero
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `LCS_ADDR_CH7_CURRENT: reg_rdata <= ch7_current_code;
            `LCS_ADDR_CH8_CURRENT: reg_rdata <= ch8_current_code;
            `LCS_ADDR_CH9_CURRENT: reg_rdata <= ch9_current_code;
            `LCS_ADDR_MISC:        reg_rdata <= {6'h00, clk_sel_reg};
            `LCS_ADDR_STATUS:      reg_rdata <= {7'h00, external_clock_in_use_flag};
            default:               reg_rdata <= 8'h00;
         endcase
      end
   end

   // detector next state: any rising edge marks the clock present and no
   // minimum period is checked, so fast clocks are never rejected
   always @* begin
      det_cnt_next     = det_cnt_reg;
      ext_present_next = ext_present_reg;
      if (ext_edge) begin
         det_cnt_next     = 17'h00000;
         ext_present_next = 1'b1;
      end else if (det_cnt_reg >= DET_LAST) begin
         // a full window of silence ends presence; the counter parks here
         ext_present_next = 1'b0;
      end else begin
         det_cnt_next = det_cnt_reg + 17'h00001;
      end
   end

   // detector and edge history flops
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         det_cnt_reg     <= 17'h00000;
         ext_present_reg <= 1'b0;
         ext_prev_reg    <= 1'b0;
         int_prev_reg    <= 1'b0;
      end else begin
         det_cnt_reg     <= det_cnt_next;
         ext_present_reg <= ext_present_next;
         ext_prev_reg    <= ext_lvl;
         int_prev_reg    <= int_lvl;
      end
   end

   // source request decoded from the select field
   always @* begin
      case (clk_sel_reg)
         `LCS_SEL_FORCED_EXT: want_ext = 1'b1;
         `LCS_SEL_AUTO:       want_ext = ext_present_reg;
         `LCS_SEL_FORCED_INT: want_ext = 1'b0;
         `LCS_SEL_INTERNAL:   want_ext = 1'b0;
         default:             want_ext = 1'b0;
      endcase
   end

   // switch source only while both clocks are low, so no runt pulse reaches
   // the engines; a dead external clock sits low, so fallback is not blocked,
   // but a source stuck high delays the switch until it drops
   always @* begin
      src_state_next = src_state_reg;
      case (src_state_reg)
         SRC_INT: begin
            if (want_ext && !int_lvl && !ext_lvl) begin
               src_state_next = SRC_EXT;
            end
         end
         SRC_EXT: begin
            if (!want_ext && !int_lvl && !ext_lvl) begin
               src_state_next = SRC_INT;
            end
         end
         default: begin
            src_state_next = SRC_INT;
         end
      endcase
   end

   // source state flop; internal oscillator after reset
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         src_state_reg <= SRC_INT;
      end else begin
         src_state_reg <= src_state_next;
      end
   end

   assign use_ext = (src_state_reg == SRC_EXT);

   // selected level and edge; the engine rate follows the source rate
   // without any correction, so a fast external clock runs them fast
   always @* begin
      exec_clk_next  = use_ext ? ext_lvl : int_lvl;
      exec_tick_next = use_ext ? ext_edge : int_edge;
      flag_next      = use_ext & clock_detect_enable;
   end

   // outputs registered so the engines and the status read see clean levels
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         exec_clk                   <= 1'b0;
         exec_tick                  <= 1'b0;
         external_clock_in_use_flag <= 1'b0;
      end else begin
         exec_clk                   <= exec_clk_next;
         exec_tick                  <= exec_tick_next;
         external_clock_in_use_flag <= flag_next;
      end
   end
endmodule
`default_nettype wire

// File: tb/lcs_checker_assertions.sv
// concurrent checks on the ports of the current and clock select block
// assumes it is bound to the top module with every port joined by name
`timescale 1ns/100ps
`default_nettype none
module lcs_checker (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic       int_osc_in,
   input wire logic       ext_clk_pin,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] ch7_current_code,
   input wire logic [7:0] ch8_current_code,
   input wire logic [7:0] ch9_current_code,
   input wire logic       exec_clk,
   input wire logic       exec_tick,
   input wire logic       external_clock_in_use_flag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // write strobes aimed at each channel
   sequence wr7_s; reg_wr && reg_addr == 8'h2C; endsequence
   sequence wr8_s; reg_wr && reg_addr == 8'h2D; endsequence
   sequence wr9_s; reg_wr && reg_addr == 8'h2E; endsequence
   ch7_write_a: assert property (wr7_s |=> ch7_current_code == $past(reg_wdata)) else $error("ch7 write lost");
   ch8_write_a: assert property (wr8_s |=> ch8_current_code == $past(reg_wdata)) else $error("ch8 write lost");
   ch9_write_a: assert property (wr9_s |=> ch9_current_code == $past(reg_wdata)) else $error("ch9 write lost");
   ch7_hold_a: assert property (!(reg_wr && reg_addr == 8'h2C) |=> $stable(ch7_current_code))
      else $error("ch7 changed without write");
   ch7_read_a: assert property (reg_rd && reg_addr == 8'h2C |=> reg_rdata == $past(ch7_current_code))
      else $error("ch7 readback wrong");
   unmapped_read_a: assert property (reg_rd && !(reg_addr inside {8'h05, 8'h2C, 8'h2D, 8'h2E, 8'h3A})
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   status_read_a: assert property (reg_rd && reg_addr == 8'h3A
      |=> reg_rdata == {7'h00, $past(external_clock_in_use_flag)}) else $error("status read wrong");
   tick_pulse_a: assert property (exec_tick |=> !exec_tick) else $error("tick longer than one cycle");
   tick_rise_a: assert property (exec_tick |-> exec_clk && !$past(exec_clk))
      else $error("tick without clock rise");
endmodule
`default_nettype wire

// File: tb/lcs_led_current_clock_select_tb.sv
// self-checking bench: register access, clock source modes and detector timeout
// assumes the design's header is on the include path
`timescale 1ns/100ps
`default_nettype none
module lcs_led_current_clock_select_tb;
   logic       mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, int_osc_in = 0, ext_clk_pin = 0, ext_en = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, v;
   wire  [7:0] reg_rdata, c7, c8, c9;
   wire        exec_clk, exec_tick, flag;
   logic [7:0] exp_q[$];
   logic       rd_seen = 0;
   int         mismatches = 0, total_checks = 0, tick_n = 0, edge_n = 0, iedge_n = 0, t0, e0;
   lcs_led_current_clock_select dut_u (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .int_osc_in(int_osc_in),
      .ext_clk_pin(ext_clk_pin), .ch7_current_code(c7), .ch8_current_code(c8), .ch9_current_code(c9),
      .exec_clk(exec_clk), .exec_tick(exec_tick), .external_clock_in_use_flag(flag));
   always #4 mclk = ~mclk;
   always #310 int_osc_in = ~int_osc_in;
   // external pin held low when unused, as a grounded pin would be
   always #200 ext_clk_pin = ext_en & ~ext_clk_pin;
   always @(posedge ext_clk_pin) edge_n++;
   always @(posedge int_osc_in) iedge_n++;
   always @(posedge mclk) if (exec_tick === 1'b1) tick_n++;
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // read data is taken one cycle after the read edge, oldest note first
   always @(posedge mclk) begin
      if (rd_seen) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
      rd_seen <= reg_rd;
   end
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) #1;
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = d;
      if (!w) exp_q.push_back(d);
      @(posedge mclk) #1;
      reg_wr = 0;
      reg_rd = 0;
   endtask
   task automatic complete_run;
      if (mismatches == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #400000;
      mismatches++;
      complete_run;
   end
   initial begin
      void'($urandom(14944));
      repeat (4) @(posedge mclk);
      #1 rst_n = 1;
      for (int i = 0; i < 3; i++) acc(0, 8'h2C + i, 8'hAF);
      acc(0, 8'h05, 8'h00);
      for (int k = 0; k < 3; k++)
         for (int i = 0; i < 3; i++) begin
            v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
            acc(1, 8'h2C + i, v);
            acc(0, 8'h2C + i, v);
         end
      acc(1, 8'h3A, 8'hFF);
      acc(0, 8'h3A, 8'h00);
      acc(0, 8'h77, 8'h00);
      acc(1, 8'h05, 8'hFF);
      acc(0, 8'h05, 8'h03);
      // forced external: ticks follow the fast pin, flag stays low without detect enable
      acc(1, 8'h05, 8'h00);
      ext_en = 1;
      repeat (200) @(posedge mclk);
      t0 = tick_n;
      e0 = edge_n;
      repeat (2000) @(posedge mclk);
      chk("tick_delta", 8'h01, 8'(((tick_n - t0) - (edge_n - e0)) inside {-1, 0, 1}));
      acc(0, 8'h3A, 8'h00);
      acc(1, 8'h05, 8'h02);
      repeat (100) @(posedge mclk);
      acc(0, 8'h3A, 8'h01);
      ext_en = 0;
      repeat (13000) @(posedge mclk);
      acc(0, 8'h3A, 8'h00);
      ext_en = 1;
      acc(1, 8'h05, 8'h01);
      repeat (100) @(posedge mclk);
      acc(0, 8'h3A, 8'h00);
      t0 = tick_n;
      e0 = iedge_n;
      repeat (2000) @(posedge mclk);
      chk("int_tick_delta", 8'h01, 8'(((tick_n - t0) - (iedge_n - e0)) inside {-1, 0, 1}));
      // mid-run reset brings the codes and the select field back to their defaults
      acc(1, 8'h2C, 8'h12);
      @(posedge mclk) #1 rst_n = 0;
      repeat (2) @(posedge mclk);
      #1 rst_n = 1;
      acc(0, 8'h2C, 8'hAF);
      acc(0, 8'h05, 8'h00);
      repeat (3) @(posedge mclk);
      complete_run;
   end
endmodule
bind lcs_led_current_clock_select lcs_checker chk_u (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .int_osc_in(int_osc_in), .ext_clk_pin(ext_clk_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .ch7_current_code(ch7_current_code), .ch8_current_code(ch8_current_code),
   .ch9_current_code(ch9_current_code), .exec_clk(exec_clk), .exec_tick(exec_tick),
   .external_clock_in_use_flag(external_clock_in_use_flag));
`default_nettype wire
